/* File: verilog/timer_pkg.sv */
// Contract
// - Compare register is checked against the count on each count tick; equality then raises match_interrupt.
// - Compare register is not initialised by reset; software writes it first.
// - Compare lowered below count: counter wraps through overflow; software restarts.
// - Valid edge on timer_input_pin copies count_register into capture_register.
// - Edge during capture read: capture skipped, edge_interrupt_flag still raised.
// - Reset clears count_register to zero.
// - Reading count_register goes through capture_register, overwriting its content.
// - Reset clears clock_select_register; it selects count clock and clock output.
// - Mode register resets to zero: mode bits 3..1, overflow bit 0.
// - Mode zero stops timer, holds count at zero, no match interrupt or output toggle; edge interrupt still raised.
// - 001 PWM, 01x free run, 10x clear on edge, 11x clear on match.
// - Non-PWM: field bit 0 clear means match only, set adds edge.
// - Overflow flag reads one once count overflow detected, else zero.
// - Output control resets to zero: set, reset, toggle, level, enable.
// - Clock select bits 6..4: pin edge, or main clock by 1,2,4,8.
// - Flip-flop set and reset command bits always read back as zero.
// - Output control bit 1 chooses the PWM active level.
// - Output control bit 0 enables driving timer output onto the pin.
`default_nettype none
package timer_pkg;
  localparam int          CNT_W          = 16;
  localparam int          DATA_W         = 16;
  localparam int          ADDR_W         = 16;
  localparam logic [15:0] ADDR_COMPARE   = 16'hff40;
  localparam logic [15:0] ADDR_CAPTURE   = 16'hff42;
  localparam logic [15:0] ADDR_COUNT     = 16'hff44;
  localparam logic [15:0] ADDR_MODE      = 16'hff48;
  localparam logic [15:0] ADDR_CLKSEL    = 16'hff4a;
  localparam logic [15:0] ADDR_OUTCTL    = 16'hff4c;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [7:0]  MODE_RST       = 8'h00;
  localparam logic [7:0]  CLKSEL_RST     = 8'h00;
  localparam logic [7:0]  OUTCTL_RST     = 8'h00;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam int          OVF_BIT        = 0;
  localparam int          MODE_LSB       = 1;
  localparam int          MODE_MSB       = 3;
  localparam int          CCLK_LSB       = 4;
  localparam int          CCLK_MSB       = 6;
  localparam int          CLKOUT_SEL_LSB = 0;
  localparam int          CLKOUT_SEL_MSB = 2;
  localparam int          CLKOUT_EN_BIT  = 7;
  localparam int          OE_BIT         = 0;
  localparam int          PWM_LVL_BIT    = 1;
  localparam int          TOGGLE_EN_BIT  = 2;
  localparam int          FF_RST_BIT     = 3;
  localparam int          FF_SET_BIT     = 4;
  localparam int          PWM_LSB        = 2;
  localparam logic [2:0]  PRESC_RST      = 3'h0;
  localparam logic [1:0]  PRESC_DIV4     = 2'h3;
  localparam logic [2:0]  PRESC_DIV8     = 3'h7;
  localparam logic [1:0]  EDGE_FALL      = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_BOTH      = 2'h2;
  localparam logic [1:0]  SAMP_RST       = 2'h0;

  typedef enum logic [2:0] {
    MODE_STOP      = 3'b000,
    MODE_PWM       = 3'b001,
    MODE_FREE      = 3'b010,
    MODE_FREE_EDGE = 3'b011,
    MODE_CLRE      = 3'b100,
    MODE_CLRE_EDGE = 3'b101,
    MODE_CLRM      = 3'b110,
    MODE_CLRM_EDGE = 3'b111
  } mode_t;

  typedef enum logic [2:0] {
    CCLK_PIN  = 3'b000,
    CCLK_DIV1 = 3'b001,
    CCLK_DIV2 = 3'b010,
    CCLK_DIV4 = 3'b011,
    CCLK_DIV8 = 3'b100
  } cclk_t;
endpackage
`default_nettype wire

/* File: verilog/timer_edge_filter.sv */
`default_nettype none
module timer_edge_filter
  import timer_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] edge_sel_i,
  output logic            edge_o
);
  logic [1:0] samp_ff;
  logic       lvl_ff;
  logic       agree;
  logic       rise;
  logic       fall;

  // Two equal samples needed, so one-sample glitches are dropped
  assign agree = samp_ff[1] == samp_ff[0];
  assign rise  = agree & samp_ff[0] & ~lvl_ff;
  assign fall  = agree & ~samp_ff[0] & lvl_ff;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      samp_ff <= SAMP_RST;
      lvl_ff  <= 1'b0;
    end else if (ce_i) begin
      samp_ff <= {samp_ff[0], pin_i};
      if (agree) begin
        lvl_ff <= samp_ff[0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      edge_o <= 1'b0;
    end else if (ce_i) begin
      if (edge_sel_i == EDGE_FALL) begin
        edge_o <= fall;
      end else if (edge_sel_i == EDGE_RISE) begin
        edge_o <= rise;
      end else if (edge_sel_i == EDGE_BOTH) begin
        edge_o <= rise | fall;
      end else begin
        edge_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/timer_event_counter_16bit.sv */
`default_nettype none
module timer_event_counter_16bit
  import timer_pkg::*;
#(
  parameter int CLKOUT_DIV_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              timer_input_pin_i,
  input  wire logic [1:0]        edge_sel_i,
  output logic                   match_interrupt_o,
  output logic                   external_edge_interrupt_o,
  output logic                   timer_output_pin_o,
  output logic                   timer_output_oe_o,
  output logic                   programmable_clock_output_o
);
  logic [CNT_W-1:0]        count_register_ff;
  logic [CNT_W-1:0]        compare_register_ff;
  logic [CNT_W-1:0]        capture_register_ff;
  mode_t                   mode_ff;
  logic                    overflow_flag_ff;
  logic [7:0]              clock_select_ff;
  logic [7:0]              output_control_ff;
  logic                    output_flipflop_ff;
  logic [2:0]              presc_ff;
  logic [CLKOUT_DIV_W-1:0] clkdiv_ff;
  logic                    valid_edge;
  logic                    running;
  logic                    tick;
  logic                    is_match;
  logic                    match_hit;
  logic                    ovf_set;
  logic                    clear_on_edge;
  logic                    clear_on_match;
  logic                    pwm_mode;
  logic                    pwm_active;
  logic                    out_event;
  logic                    wr_mode;
  logic                    wr_outctl;
  logic                    rd_capture;
  logic                    rd_count;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    hit = a == r;
  endfunction

  function automatic logic count_tick(input logic [2:0] sel,
                                      input logic [2:0] p,
                                      input logic       e);
    count_tick = 1'b0;
    case (sel)
      CCLK_PIN:  count_tick = e;
      CCLK_DIV1: count_tick = 1'b1;
      CCLK_DIV2: count_tick = p[0];
      CCLK_DIV4: count_tick = p[1:0] == PRESC_DIV4;
      CCLK_DIV8: count_tick = p == PRESC_DIV8;
      default:   count_tick = 1'b0;
    endcase
  endfunction

  timer_edge_filter u_edge (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .pin_i      (timer_input_pin_i),
    .edge_sel_i (edge_sel_i),
    .edge_o     (valid_edge)
  );

  assign wr_mode        = reg_wr_i & hit(reg_addr_i, ADDR_MODE);
  assign wr_outctl      = reg_wr_i & hit(reg_addr_i, ADDR_OUTCTL);
  assign rd_capture     = reg_rd_i & hit(reg_addr_i, ADDR_CAPTURE);
  assign rd_count       = reg_rd_i & hit(reg_addr_i, ADDR_COUNT);
  assign running        = mode_ff != MODE_STOP;
  assign pwm_mode       = mode_ff == MODE_PWM;
  // Prohibited clock codes simply never tick
  assign tick           = running & count_tick(
                            clock_select_ff[CCLK_MSB:CCLK_LSB],
                            presc_ff, valid_edge);
  assign is_match       = count_register_ff == compare_register_ff;
  assign match_hit      = tick & is_match;
  assign ovf_set        = tick & (count_register_ff == CNT_MAX);
  assign clear_on_edge  = running & mode_ff[2] & ~mode_ff[1] &
                          valid_edge;
  assign clear_on_match = mode_ff[2] & mode_ff[1];
  assign pwm_active     = count_register_ff[CNT_W-1:PWM_LSB] <
                          compare_register_ff[CNT_W-1:PWM_LSB];
  assign out_event      = output_control_ff[TOGGLE_EN_BIT] & ~pwm_mode &
                          running &
                          (match_hit | (mode_ff[0] & valid_edge));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      presc_ff  <= PRESC_RST;
      clkdiv_ff <= '0;
    end else if (ce_i) begin
      presc_ff  <= presc_ff + 3'h1;
      clkdiv_ff <= clkdiv_ff + CLKOUT_DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      count_register_ff <= CNT_ZERO;
    end else if (ce_i) begin
      if (!running) begin
        count_register_ff <= CNT_ZERO;
      end else if (clear_on_edge) begin
        count_register_ff <= CNT_ZERO;
      end else if (tick) begin
        if (clear_on_match && is_match) begin
          count_register_ff <= CNT_ZERO;
        end else begin
          // Below-count compare just wraps through FFFF
          count_register_ff <= count_register_ff + 16'h0001;
        end
      end
    end
  end

  // Not reset: stays undefined until software writes it
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && reg_wr_i && hit(reg_addr_i, ADDR_COMPARE)) begin
      compare_register_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (rd_count) begin
        capture_register_ff <= count_register_ff;
      end else if (valid_edge && !rd_capture) begin
        capture_register_ff <= count_register_ff;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mode_ff          <= mode_t'(MODE_RST[MODE_MSB:MODE_LSB]);
      overflow_flag_ff <= MODE_RST[OVF_BIT];
    end else if (ce_i) begin
      if (wr_mode) begin
        mode_ff <= mode_t'(reg_wdata_i[MODE_MSB:MODE_LSB]);
      end
      // Hardware set wins over a software clear in the same cycle
      if (ovf_set) begin
        overflow_flag_ff <= 1'b1;
      end else if (wr_mode && !reg_wdata_i[OVF_BIT]) begin
        overflow_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clock_select_ff <= CLKSEL_RST;
    end else if (ce_i && reg_wr_i && hit(reg_addr_i, ADDR_CLKSEL)) begin
      clock_select_ff <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      output_control_ff <= OUTCTL_RST;
    end else if (ce_i && wr_outctl) begin
      output_control_ff <= reg_wdata_i[7:0];
      output_control_ff[FF_RST_BIT] <= 1'b0;
      output_control_ff[FF_SET_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      output_flipflop_ff <= 1'b0;
    end else if (ce_i) begin
      if (wr_outctl && reg_wdata_i[FF_SET_BIT]) begin
        output_flipflop_ff <= 1'b1;
      end else if (wr_outctl && reg_wdata_i[FF_RST_BIT]) begin
        output_flipflop_ff <= 1'b0;
      end else if (out_event) begin
        output_flipflop_ff <= ~output_flipflop_ff;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      timer_output_pin_o <= 1'b0;
      timer_output_oe_o  <= 1'b0;
    end else if (ce_i) begin
      timer_output_oe_o <= output_control_ff[OE_BIT];
      if (!output_control_ff[OE_BIT]) begin
        timer_output_pin_o <= 1'b0;
      end else if (pwm_mode) begin
        timer_output_pin_o <= pwm_active ~^
                              output_control_ff[PWM_LVL_BIT];
      end else begin
        timer_output_pin_o <= output_flipflop_ff;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      match_interrupt_o         <= 1'b0;
      external_edge_interrupt_o <= 1'b0;
    end else if (ce_i) begin
      match_interrupt_o         <= match_hit;
      external_edge_interrupt_o <= valid_edge;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      programmable_clock_output_o <= 1'b0;
    end else if (ce_i) begin
      programmable_clock_output_o <= clock_select_ff[CLKOUT_EN_BIT] &
        clkdiv_ff[clock_select_ff[CLKOUT_SEL_MSB:CLKOUT_SEL_LSB]];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= CNT_ZERO;
    end else if (ce_i && reg_rd_i) begin
      if (hit(reg_addr_i, ADDR_COMPARE)) begin
        reg_rdata_o <= compare_register_ff;
      end else if (hit(reg_addr_i, ADDR_CAPTURE)) begin
        reg_rdata_o <= capture_register_ff;
      end else if (hit(reg_addr_i, ADDR_COUNT)) begin
        reg_rdata_o <= count_register_ff;
      end else if (hit(reg_addr_i, ADDR_MODE)) begin
        reg_rdata_o <= {BYTE_ZERO, 4'h0, mode_ff,
                        overflow_flag_ff};
      end else if (hit(reg_addr_i, ADDR_CLKSEL)) begin
        reg_rdata_o <= {BYTE_ZERO, clock_select_ff};
      end else if (hit(reg_addr_i, ADDR_OUTCTL)) begin
        reg_rdata_o <= {BYTE_ZERO, output_control_ff};
      end else begin
        reg_rdata_o <= CNT_ZERO;
      end
    end
  end

  match_irq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && match_hit |=> match_interrupt_o)
    else $error("match without interrupt");

  no_match_irq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && !running |=> !match_interrupt_o)
    else $error("interrupt while stopped");

  stop_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && !wr_mode && !running |=> ##1
      (count_register_ff == CNT_ZERO) || $past(running))
    else $error("count not held at zero");

  reset_regs_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $past(srst_i) |-> count_register_ff == CNT_ZERO &&
      clock_select_ff == CLKSEL_RST && output_control_ff == OUTCTL_RST &&
      mode_ff == MODE_STOP && !overflow_flag_ff)
    else $error("reset values wrong");

  ovf_sticky_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && ovf_set |=> overflow_flag_ff ##1
      (overflow_flag_ff || $past(wr_mode)))
    else $error("overflow flag lost");

  capture_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && valid_edge && !rd_capture |=>
      capture_register_ff == $past(count_register_ff))
    else $error("capture missed");

  cap_skip_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && valid_edge && rd_capture |=>
      capture_register_ff == $past(capture_register_ff) &&
      external_edge_interrupt_o)
    else $error("capture not skipped during read");

  count_read_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && rd_count |=> capture_register_ff == reg_rdata_o &&
      reg_rdata_o == $past(count_register_ff))
    else $error("count read not via capture");

  clear_match_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && match_hit && clear_on_match && !clear_on_edge |=>
      count_register_ff == CNT_ZERO)
    else $error("no clear on match");

  cmd_bits_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && wr_outctl |=> !output_control_ff[FF_SET_BIT] &&
      !output_control_ff[FF_RST_BIT])
    else $error("command bits stuck");

  toggle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && out_event && !wr_outctl |=>
      output_flipflop_ff != $past(output_flipflop_ff))
    else $error("output flip-flop did not toggle");

  pin_off_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ce_i && !output_control_ff[OE_BIT] |=>
      !timer_output_pin_o && !timer_output_oe_o)
    else $error("pin driven while disabled");

  cover_match_c: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    match_hit && clear_on_match);
  cover_ovf_c: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    ovf_set);
  cover_skip_c: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    valid_edge && rd_capture);
  cover_pwm_c: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    pwm_mode && output_control_ff[OE_BIT] && pwm_active);
endmodule
`default_nettype wire

/* File: verilog/_unused.sv */
`default_nettype none
`default_nettype wire

/* File: tb/timer_pin_model.sv */
`default_nettype none
module timer_pin_model (
  input  wire logic        clk_i,
  input  wire logic        fire_i,
  input  wire logic [3:0]  width_i,
  input  wire logic        out_pin_i,
  input  wire logic        out_oe_i,
  output logic             pin_o,
  output logic             busy_o,
  output logic [15:0]      toggles_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left_ff = 5'h00;
  logic       last_ff = 1'b0;
  initial toggles_o = 16'h0000;
  // Pulse source: width_i cycles high, then as many low
  always @(posedge clk_i) begin
    if (fire_i && !busy_o) begin
      left_ff <= {width_i, 1'b0};
    end else if (left_ff != 5'h00) begin
      left_ff <= left_ff - 5'h01;
    end
    last_ff <= out_pin_i;
    // Load only sees level changes while the pin is driven
    if (out_oe_i && last_ff !== out_pin_i) begin
      toggles_o <= toggles_o + 16'h0001;
    end
  end
  assign pin_o  = left_ff > {1'b0, width_i};
  assign busy_o = left_ff != 5'h00;
endmodule
`default_nettype wire

/* File: tb/test_timer_event_counter_16bit.sv */
`default_nettype none
module test_timer_event_counter_16bit;
  import timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys  = 1'b0;
  logic              srst     = 1'b1;
  logic              ce       = 1'b1;
  logic              wr       = 1'b0;
  logic              rd       = 1'b0;
  logic              fire     = 1'b0;
  logic              pend     = 1'b0;
  logic [1:0]        edge_sel = 2'h1;
  logic [3:0]        width    = 4'h3;
  logic [ADDR_W-1:0] addr     = 16'h0000;
  logic [DATA_W-1:0] wdata    = 16'h0000;
  logic [31:0]       seed     = 32'h791747b1;
  logic [DATA_W-1:0] rdata;
  logic [15:0]       toggles, t0, cmp, r, want_now;
  logic              pin, busy, match, ext_edge, out_pin, out_oe, clk_out;
  logic              last;
  logic [15:0]       exp_q[$];
  int                failures = 0;
  int                total_checks = 0;
  int                n_match = 0;
  int                n_edge = 0;
  int                m0, e0, k, n;

  always #4 clk_sys = ~clk_sys;

  timer_event_counter_16bit DUT (
    .clk_sys_i(clk_sys), .srst_i(srst), .ce_i(ce), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .timer_input_pin_i(pin), .edge_sel_i(edge_sel),
    .match_interrupt_o(match), .external_edge_interrupt_o(ext_edge),
    .timer_output_pin_o(out_pin), .timer_output_oe_o(out_oe),
    .programmable_clock_output_o(clk_out)
  );

  timer_pin_model pin_load (
    .clk_i(clk_sys), .fire_i(fire), .width_i(width), .out_pin_i(out_pin),
    .out_oe_i(out_oe), .pin_o(pin), .busy_o(busy), .toggles_o(toggles)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic idle(input int cycles);
    repeat (cycles) @(negedge clk_sys);
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [15:0] want);
    @(negedge clk_sys);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(want);
    @(negedge clk_sys);
    rd = 1'b0;
  endtask

  task automatic pulse(input logic [3:0] w);
    int guard;
    @(negedge clk_sys);
    width = w;
    fire = 1'b1;
    @(negedge clk_sys);
    fire = 1'b0;
    guard = 0;
    while (busy && guard < 64) begin
      idle(1);
      guard++;
    end
    // Filter needs about four cycles to report the edge
    idle(6);
  endtask

  always @(posedge clk_sys) begin
    pend <= rd && ce;
    if (match === 1'b1) n_match <= n_match + 1;
    if (ext_edge === 1'b1) n_edge <= n_edge + 1;
  end

  // Read data lands one cycle after the strobe; oldest note is compared
  always @(negedge clk_sys) begin
    if (pend && exp_q.size() > 0) begin
      want_now = exp_q.pop_front();
      check(rdata, want_now);
    end
  end

  initial begin
    // About 97,500 cycles; a clean run needs roughly 66,500
    #780_000;
    failures++;
    summarize();
  end

  initial begin
    idle(8);
    srst = 1'b0;
    check({14'h0, out_pin, out_oe}, 16'h0000);
    rd_reg(ADDR_MODE, 16'h0000);
    rd_reg(ADDR_CLKSEL, 16'h0000);
    rd_reg(ADDR_OUTCTL, 16'h0000);
    rd_reg(ADDR_COUNT, 16'h0000);
    rd_reg(16'hff50, 16'h0000);
    for (k = 1; k < 8; k++) begin
      wr_reg(ADDR_MODE, 16'(k << 1));
      rd_reg(ADDR_MODE, 16'(k << 1));
      wr_reg(ADDR_MODE, 16'h0000);
    end
    for (k = 0; k < 5; k++) begin
      wr_reg(ADDR_CLKSEL, 16'(k << 4));
      rd_reg(ADDR_CLKSEL, 16'(k << 4));
    end
    ce = 1'b0;
    wr_reg(ADDR_OUTCTL, 16'h00e0);
    ce = 1'b1;
    rd_reg(ADDR_OUTCTL, 16'h0000);
    r = 16'(rnd());
    wr_reg(ADDR_OUTCTL, {8'h00, r[2:0], 5'h11});
    rd_reg(ADDR_OUTCTL, {8'h00, r[2:0], 5'h01});
    check({14'h0, out_pin, out_oe}, 16'h0003);
    wr_reg(ADDR_OUTCTL, 16'h0009);
    idle(2);
    check({14'h0, out_pin, out_oe}, 16'h0001);
    wr_reg(ADDR_OUTCTL, 16'h0010);
    idle(2);
    check({14'h0, out_pin, out_oe}, 16'h0000);
    wr_reg(ADDR_CLKSEL, 16'h0010);
    idle(20);
    rd_reg(ADDR_COUNT, 16'h0000);
    wr_reg(ADDR_MODE, 16'h0004);
    rd_reg(ADDR_COUNT, 16'h0001);
    rd_reg(ADDR_CAPTURE, 16'h0001);
    wr_reg(ADDR_MODE, 16'h0000);
    cmp = 16'(rnd() % 8 + 2);
    wr_reg(ADDR_OUTCTL, 16'h0005);
    wr_reg(ADDR_COMPARE, cmp);
    wr_reg(ADDR_MODE, 16'h000c);
    idle(12);
    m0 = n_match;
    t0 = toggles;
    idle(8 * (cmp + 1));
    check(16'(n_match - m0), 16'h0008);
    check(toggles - t0, 16'h0008);
    wr_reg(ADDR_MODE, 16'h0000);
    wr_reg(ADDR_OUTCTL, 16'h0003);
    wr_reg(ADDR_MODE, 16'h0002);
    wr_reg(ADDR_COMPARE, 16'hfffc);
    idle(4);
    check({15'h0, out_pin}, 16'h0001);
    wr_reg(ADDR_MODE, 16'h0000);
    wr_reg(ADDR_OUTCTL, 16'h0001);
    wr_reg(ADDR_MODE, 16'h0002);
    idle(4);
    check({15'h0, out_pin}, 16'h0000);
    wr_reg(ADDR_MODE, 16'h0000);
    for (n = 0; n < 3; n++) begin
      wr_reg(ADDR_CLKSEL, 16'h0010 | 16'(n));
      wr_reg(ADDR_CLKSEL, 16'h0090 | 16'(n));
      idle(2);
      k = 0;
      last = clk_out;
      repeat (16) begin
        idle(1);
        if (clk_out !== last) k++;
        last = clk_out;
      end
      check(16'(k), 16'(16 >> n));
    end
    wr_reg(ADDR_CLKSEL, 16'h0000);
    wr_reg(ADDR_MODE, 16'h0004);
    e0 = n_edge;
    repeat (5) pulse(4'(rnd() % 4 + 2));
    rd_reg(ADDR_COUNT, 16'h0005);
    pulse(4'h3);
    pulse(4'h2);
    rd_reg(ADDR_CAPTURE, 16'h0006);
    rd_reg(ADDR_COUNT, 16'h0007);
    check(16'(n_edge - e0), 16'h0007);
    wr_reg(ADDR_MODE, 16'h0000);
    edge_sel = 2'h3;
    pulse(4'h3);
    check(16'(n_edge - e0), 16'h0007);
    edge_sel = 2'h1;
    // Clear on edge, output toggles on edge too
    wr_reg(ADDR_OUTCTL, 16'h0005);
    wr_reg(ADDR_MODE, 16'h000a);
    t0 = toggles;
    pulse(4'h3);
    pulse(4'h3);
    check(toggles - t0, 16'h0002);
    rd_reg(ADDR_COUNT, 16'h0000);
    wr_reg(ADDR_MODE, 16'h0000);
    // Long run: lowered compare forces a trip through overflow
    wr_reg(ADDR_CLKSEL, 16'h0010);
    wr_reg(ADDR_COMPARE, 16'h8000);
    wr_reg(ADDR_MODE, 16'h000c);
    idle(40);
    wr_reg(ADDR_COMPARE, 16'h0005);
    m0 = n_match;
    idle(60000);
    check(16'(n_match - m0), 16'h0000);
    rd_reg(ADDR_MODE, 16'h000c);
    idle(6000);
    rd_reg(ADDR_MODE, 16'h000d);
    wr_reg(ADDR_MODE, 16'h000c);
    rd_reg(ADDR_MODE, 16'h000c);
    wr_reg(ADDR_MODE, 16'h0000);
    idle(3);
    summarize();
  end
endmodule
`default_nettype wire
